// *** rtl/otp_pkg.sv ***
/*
 * Shared constants for the security register link: opcodes, sizes,
 * status bit positions and timing counts.
 * Assumes a 50 MHz system clock on both ends.
 */
package otp_pkg;
	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_STAT = 8'h05;
	localparam logic [7:0] OP_PROG = 8'h9b;
	localparam logic [7:0] OP_READ = 8'h77;

	// ****************************************
	// Sizes and frame layout
	// ****************************************
	localparam int SEC_BYTES = 128;
	localparam int USER_BYTES = 64;
	localparam int BUF_BYTES = 256;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [2:0] HDR_WREN = 3'h1;
	localparam logic [2:0] HDR_STAT = 3'h1;
	localparam logic [2:0] HDR_PROG = 3'h4;
	localparam logic [2:0] HDR_READ = 3'h6;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ****************************************
	// Status bits
	// ****************************************
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 50;
	localparam int SECURITY_PROGRAM_TIME_US = 200;
	localparam int SEC_PROG_CYCLES = SECURITY_PROGRAM_TIME_US * CLK_MHZ;
	localparam logic [3:0] HOST_HALF = 4'h6;

	// ****************************************
	// Host command kinds
	// ****************************************
	typedef enum logic [1:0] {OTP_CMD_WREN, OTP_CMD_STAT, OTP_CMD_PROG, OTP_CMD_READ} otp_cmd_t;
endpackage

// *** rtl/otp_spi_if.sv ***
/*
 * Serial link between the host controller and the security register.
 * The serial output wire is resolved here from its enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface otp_spi_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe_n;
	wire miso;

	// Released wire reads as pulled high
	assign miso = miso_oe_n ? 1'b1 : miso_o;

	modport dev (input sck, input cs_n, input mosi, output miso_o, output miso_oe_n);
	modport host (output sck, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// *** rtl/otp_dev.sv ***
/*
 * Security register command logic of the serial memory device.
 * Link side runs on the serial clock; the self-timed program engine,
 * the write enable latch and the register array run on clk.
 * Assumes a mode 0 host that stops the serial clock before releasing select.
 */
// Function
// - 128 bytes: 64 user, 64 factory
// - Programmed user area never programmed again
// - Factory area 64..127 never changes
// - One program covers area, no erase
// - Host sets write enable latch first
// - Program: 9Bh, three address bytes, data
// - Program decodes only address bits 5..0
// - Data past location 63 wraps to 0
// - Over 64 bytes keeps last 64
// - Program on select rise, unwritten stay FFh
// - Program cycle is internally timed
// - Abort on short address, data, misalignment
// - Abort clears write enable latch
// - Busy reported while programming
// - Latch cleared before program completes
// - Interrupted area still counts as used; here reset clears used_reg and erases the area
// - Uses shared 256-byte buffer
// - Read: 77h, address, two dummies, data
// - Read wraps from 7Fh to 00h seamlessly
// - Select rise ends read, output released
// - Status bit 1 is write enable latch
// - Status bit 0 is busy flag
`timescale 1ns/1ps
`default_nettype none
module otp_dev #(
	parameter int PROG_CYCLES = otp_pkg::SEC_PROG_CYCLES,
	// Factory contents: arbitrary value
	parameter logic [511:0] FACTORY_DATA = {8{64'h0f1e2d3c4b5a6978}}
) (
	input wire logic clk,
	input wire logic arst_n,
	otp_spi_if.dev link,
	output logic busy_o,
	output logic wel_o,
	output logic used_o
);
	typedef enum {OTP_IDLE, OTP_PROG} otp_state_t;

	// ****************************************
	// Link side state
	// ****************************************
	logic first_reg;
	logic frame_tgl_reg;
	logic [2:0] bit_cnt_reg;
	logic [2:0] byte_cnt_reg;
	logic [6:0] sh_reg;
	logic [7:0] opcode_reg;
	logic [6:0] addr_reg;
	logic [5:0] ptr_reg;
	logic [6:0] rd_ptr_reg;
	logic [7:0] buf_reg [otp_pkg::BUF_BYTES];
	logic [63:0] mask_reg;
	logic [1:0] st1_reg, st2_reg, st3_reg, stat_reg;
	logic so_reg, so_oe_n_reg;
	logic [2:0] cur_bit, cur_byte;
	logic [7:0] rx_byte;
	logic byte_done;
	logic [7:0] rd_byte, st_byte;

	// ****************************************
	// System side state
	// ****************************************
	otp_state_t state_reg;
	logic cs1_reg, cs2_reg, cs3_reg, cs_lvl_reg;
	logic seen_tgl_reg;
	logic busy_reg, wel_reg, used_reg;
	logic [31:0] timer_reg;
	logic [7:0] user_reg [otp_pkg::USER_BYTES];
	logic cs_rise, frame_new, aligned;

	function automatic logic [7:0] sec_byte(input logic [6:0] idx);
		if (idx[6]) begin
			sec_byte = FACTORY_DATA[{idx[5:0], 3'h0} +: 8];
		end else begin
			sec_byte = user_reg[idx[5:0]];
		end
	endfunction

	// Position of the bit now arriving; a new frame restarts at zero
	always_comb begin
		cur_bit = first_reg ? 3'h0 : bit_cnt_reg;
		cur_byte = first_reg ? 3'h0 : byte_cnt_reg;
		rx_byte = {sh_reg, link.mosi};
		byte_done = (cur_bit == otp_pkg::LAST_BIT);
		rd_byte = sec_byte(rd_ptr_reg);
		st_byte = {6'h0, stat_reg};
	end

	// Frame start flag, set while select is high
	always_ff @(posedge link.sck or posedge link.cs_n or negedge arst_n) begin
		if (!arst_n) begin
			first_reg <= 1'b1;
		end else if (link.cs_n) begin
			first_reg <= 1'b1;
		end else begin
			first_reg <= 1'b0;
		end
	end

	// Bit and byte counting, MSB first
	always_ff @(posedge link.sck or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
			sh_reg <= 7'h0;
			frame_tgl_reg <= 1'b0;
		end else begin
			bit_cnt_reg <= cur_bit + 3'h1;
			sh_reg <= rx_byte[6:0];
			if (first_reg) begin
				frame_tgl_reg <= ~frame_tgl_reg;
			end
			if (byte_done && cur_byte != 3'h7) begin
				byte_cnt_reg <= cur_byte + 3'h1;
			end else begin
				byte_cnt_reg <= cur_byte;
			end
		end
	end

	always_ff @(posedge link.sck or negedge arst_n) begin
		if (!arst_n) begin
			opcode_reg <= 8'h0;
			addr_reg <= 7'h0;
		end else begin
			if (first_reg) begin
				opcode_reg <= 8'h0;
			end
			if (byte_done && cur_byte == 3'h0) begin
				opcode_reg <= rx_byte;
			end
			if (byte_done && cur_byte == 3'h3) begin
				addr_reg <= rx_byte[6:0];
			end
		end
	end

	// Shared buffer fill, ignored while busy
	always_ff @(posedge link.sck or negedge arst_n) begin
		if (!arst_n) begin
			ptr_reg <= 6'h0;
			mask_reg <= 64'h0;
		end else if (opcode_reg == otp_pkg::OP_PROG && byte_done && !stat_reg[otp_pkg::ST_BUSY]) begin
			if (cur_byte == 3'h3) begin
				ptr_reg <= rx_byte[5:0];
				mask_reg <= 64'h0;
			end else if (cur_byte >= otp_pkg::HDR_PROG) begin
				ptr_reg <= ptr_reg + 6'h1;
				mask_reg[ptr_reg] <= 1'b1;
			end
		end
	end

	always_ff @(posedge link.sck) begin
		if (opcode_reg == otp_pkg::OP_PROG && byte_done && !stat_reg[otp_pkg::ST_BUSY]
			&& cur_byte >= otp_pkg::HDR_PROG) begin
			buf_reg[{2'h0, ptr_reg}] <= rx_byte;
		end
	end

	// Read pointer, seven bits wrap 7Fh to 00h
	always_ff @(posedge link.sck or negedge arst_n) begin
		if (!arst_n) begin
			rd_ptr_reg <= 7'h0;
		end else if (byte_done && cur_byte == 3'h5) begin
			rd_ptr_reg <= addr_reg;
		end else if (byte_done && cur_byte >= otp_pkg::HDR_READ) begin
			rd_ptr_reg <= rd_ptr_reg + 7'h1;
		end
	end

	// Status into the link domain; taken once two late stages agree
	always_ff @(posedge link.sck or negedge arst_n) begin
		if (!arst_n) begin
			st1_reg <= 2'h0;
			st2_reg <= 2'h0;
			st3_reg <= 2'h0;
			stat_reg <= 2'h0;
		end else begin
			st1_reg <= {wel_reg, busy_reg};
			st2_reg <= st1_reg;
			st3_reg <= st2_reg;
			if (st2_reg == st3_reg) begin
				stat_reg <= st3_reg;
			end
		end
	end

	// Read output after dummies, status after opcode; falling edge drive
	// Select rise releases output at once
	always_ff @(negedge link.sck or posedge link.cs_n or negedge arst_n) begin
		if (!arst_n) begin
			so_reg <= 1'b0;
			so_oe_n_reg <= 1'b1;
		end else if (link.cs_n) begin
			so_reg <= 1'b0;
			so_oe_n_reg <= 1'b1;
		end else if (!first_reg && opcode_reg == otp_pkg::OP_READ && byte_cnt_reg >= otp_pkg::HDR_READ) begin
			so_reg <= rd_byte[3'h7 - bit_cnt_reg];
			so_oe_n_reg <= 1'b0;
		end else if (!first_reg && opcode_reg == otp_pkg::OP_STAT && byte_cnt_reg >= otp_pkg::HDR_STAT) begin
			so_reg <= st_byte[3'h7 - bit_cnt_reg];
			so_oe_n_reg <= 1'b0;
		end else begin
			so_reg <= 1'b0;
			so_oe_n_reg <= 1'b1;
		end
	end

	assign link.miso_o = so_reg;
	assign link.miso_oe_n = so_oe_n_reg;

	// ****************************************
	// System clock side
	// ****************************************

	// Select synchroniser and rise detect
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs1_reg <= 1'b1;
			cs2_reg <= 1'b1;
			cs3_reg <= 1'b1;
			cs_lvl_reg <= 1'b1;
		end else begin
			cs1_reg <= link.cs_n;
			cs2_reg <= cs1_reg;
			cs3_reg <= cs2_reg;
			if (cs2_reg == cs3_reg) begin
				cs_lvl_reg <= cs3_reg;
			end
		end
	end

	// Link registers are frozen while select is high, so read them here
	always_comb begin
		cs_rise = !cs_lvl_reg && cs2_reg && cs3_reg;
		frame_new = (frame_tgl_reg != seen_tgl_reg);
		aligned = (bit_cnt_reg == 3'h0);
	end

	// Frame accounting
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_tgl_reg <= 1'b0;
		end else if (cs_rise) begin
			seen_tgl_reg <= frame_tgl_reg;
		end
	end

	// Command commit and self-timed program engine
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= OTP_IDLE;
			busy_reg <= 1'b0;
			wel_reg <= 1'b0;
			used_reg <= 1'b0;
			timer_reg <= 32'h0;
		end else begin
			case (state_reg)
				OTP_IDLE: begin
					if (cs_rise && frame_new) begin
						if (opcode_reg == otp_pkg::OP_WREN && aligned) begin
							wel_reg <= 1'b1;
						end else if (opcode_reg == otp_pkg::OP_PROG && wel_reg) begin
							// Latch cleared on abort or start
							wel_reg <= 1'b0;
							// Need address, one whole data byte, alignment
							if (byte_cnt_reg > otp_pkg::HDR_PROG && aligned && !used_reg) begin
								used_reg <= 1'b1;
								busy_reg <= 1'b1;
								timer_reg <= 32'h0;
								state_reg <= OTP_PROG;
							end
						end
					end
				end
				OTP_PROG: begin
					if (timer_reg == 32'(PROG_CYCLES - 1)) begin
						busy_reg <= 1'b0;
						state_reg <= OTP_IDLE;
					end else begin
						timer_reg <= timer_reg + 32'h1;
					end
				end
				default: begin
					state_reg <= OTP_IDLE;
				end
			endcase
		end
	end

	// Write marked bytes at cycle end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < otp_pkg::USER_BYTES; i++) begin
				user_reg[i] <= otp_pkg::ERASED;
			end
		end else if (state_reg == OTP_PROG && timer_reg == 32'(PROG_CYCLES - 1)) begin
			for (int i = 0; i < otp_pkg::USER_BYTES; i++) begin
				if (mask_reg[i]) begin
					user_reg[i] <= buf_reg[i];
				end
			end
		end
	end

	assign busy_o = busy_reg;
	assign wel_o = wel_reg;
	assign used_o = used_reg;
endmodule
`default_nettype wire

// *** rtl/otp_host.sv ***
/*
 * Host controller end: runs one serial frame per command, making the
 * serial clock by dividing clk (mode 0, MSB first).
 * Assumes the user supplies write data when asked and polls status itself.
 */
`timescale 1ns/1ps
`default_nettype none
module otp_host (
	input wire logic clk,
	input wire logic arst_n,
	otp_spi_if.host link,
	input wire logic cmd_valid,
	input wire otp_pkg::otp_cmd_t cmd_op,
	input wire logic [23:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	input wire logic [7:0] wr_data,
	output logic cmd_ready,
	output logic wr_take,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done
);
	typedef enum {OTP_H_IDLE, OTP_H_RUN, OTP_H_END} otp_hstate_t;

	otp_hstate_t state_reg;
	otp_pkg::otp_cmd_t op_reg;
	logic [23:0] addr_reg;
	logic [3:0] div_reg;
	logic sck_reg, cs_n_reg, mosi_reg;
	logic [7:0] tx_reg, rx_reg;
	logic [2:0] bit_reg;
	logic [8:0] byte_reg, total_reg;
	logic [2:0] hdr_reg;
	logic m1_reg, m2_reg, m3_reg, miso_lvl_reg;
	logic ready_reg, take_reg, rdv_reg, done_reg;
	logic [7:0] rdd_reg;
	logic half_tick;
	logic [8:0] nxt_byte;
	logic [7:0] first_tx, next_tx;

	// Header length per command kind
	function automatic logic [2:0] hdr_len(input otp_pkg::otp_cmd_t op);
		case (op)
			otp_pkg::OTP_CMD_PROG: hdr_len = otp_pkg::HDR_PROG;
			otp_pkg::OTP_CMD_READ: hdr_len = otp_pkg::HDR_READ;
			otp_pkg::OTP_CMD_STAT: hdr_len = otp_pkg::HDR_STAT;
			default: hdr_len = otp_pkg::HDR_WREN;
		endcase
	endfunction

	// Byte to send at a given frame position
	function automatic logic [7:0] tx_byte(input otp_pkg::otp_cmd_t op, input logic [8:0] idx,
		input logic [23:0] addr, input logic [7:0] wd);
		if (idx == 9'h0) begin
			case (op)
				otp_pkg::OTP_CMD_PROG: tx_byte = otp_pkg::OP_PROG;
				otp_pkg::OTP_CMD_READ: tx_byte = otp_pkg::OP_READ;
				otp_pkg::OTP_CMD_STAT: tx_byte = otp_pkg::OP_STAT;
				default: tx_byte = otp_pkg::OP_WREN;
			endcase
		end else if (idx == 9'h1) begin
			tx_byte = addr[23:16];
		end else if (idx == 9'h2) begin
			tx_byte = addr[15:8];
		end else if (idx == 9'h3) begin
			tx_byte = addr[7:0];
		end else if (op == otp_pkg::OTP_CMD_PROG) begin
			tx_byte = wd;
		end else begin
			tx_byte = 8'h0;
		end
	endfunction

	// Divider tick, next byte index and the bytes to send
	always_comb begin
		half_tick = (div_reg == otp_pkg::HOST_HALF - 4'h1);
		nxt_byte = byte_reg + 9'h1;
		first_tx = tx_byte(cmd_op, 9'h0, cmd_addr, wr_data);
		next_tx = tx_byte(op_reg, nxt_byte, addr_reg, wr_data);
	end

	// Serial input synchroniser; taken once two late stages agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			m1_reg <= 1'b1;
			m2_reg <= 1'b1;
			m3_reg <= 1'b1;
			miso_lvl_reg <= 1'b1;
		end else begin
			m1_reg <= link.miso;
			m2_reg <= m1_reg;
			m3_reg <= m2_reg;
			if (m2_reg == m3_reg) begin
				miso_lvl_reg <= m3_reg;
			end
		end
	end

	// Frame sequencer and clock divider
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= OTP_H_IDLE;
			op_reg <= otp_pkg::OTP_CMD_WREN;
			addr_reg <= 24'h0;
			div_reg <= 4'h0;
			sck_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			mosi_reg <= 1'b0;
			tx_reg <= 8'h0;
			rx_reg <= 8'h0;
			bit_reg <= 3'h0;
			byte_reg <= 9'h0;
			total_reg <= 9'h0;
			hdr_reg <= 3'h0;
			ready_reg <= 1'b0;
			take_reg <= 1'b0;
			rdv_reg <= 1'b0;
			rdd_reg <= 8'h0;
			done_reg <= 1'b0;
		end else begin
			take_reg <= 1'b0;
			rdv_reg <= 1'b0;
			done_reg <= 1'b0;
			div_reg <= half_tick ? 4'h0 : div_reg + 4'h1;
			case (state_reg)
				OTP_H_IDLE: begin
					ready_reg <= 1'b1;
					if (cmd_valid && ready_reg) begin
						// User sends write enable before program
						ready_reg <= 1'b0;
						op_reg <= cmd_op;
						addr_reg <= cmd_addr;
						hdr_reg <= hdr_len(cmd_op);
						total_reg <= {6'h0, hdr_len(cmd_op)} + {1'b0, cmd_len};
						tx_reg <= first_tx;
						mosi_reg <= first_tx[7];
						cs_n_reg <= 1'b0;
						bit_reg <= 3'h0;
						byte_reg <= 9'h0;
						div_reg <= 4'h0;
						state_reg <= OTP_H_RUN;
					end
				end
				OTP_H_RUN: begin
					if (half_tick && !sck_reg) begin
						sck_reg <= 1'b1;
						rx_reg <= {rx_reg[6:0], miso_lvl_reg};
						if (bit_reg == otp_pkg::LAST_BIT && byte_reg >= {6'h0, hdr_reg}
							&& (op_reg == otp_pkg::OTP_CMD_READ || op_reg == otp_pkg::OTP_CMD_STAT)) begin
							rdv_reg <= 1'b1;
							rdd_reg <= {rx_reg[6:0], miso_lvl_reg};
						end
					end else if (half_tick) begin
						sck_reg <= 1'b0;
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg != otp_pkg::LAST_BIT) begin
							mosi_reg <= tx_reg[3'h6 - bit_reg];
						end else if (nxt_byte == total_reg) begin
							state_reg <= OTP_H_END;
						end else begin
							byte_reg <= nxt_byte;
							tx_reg <= next_tx;
							mosi_reg <= next_tx[7];
							take_reg <= (op_reg == otp_pkg::OTP_CMD_PROG && nxt_byte >= {6'h0, otp_pkg::HDR_PROG});
						end
					end
				end
				OTP_H_END: begin
					if (half_tick && !cs_n_reg) begin
						cs_n_reg <= 1'b1;
						done_reg <= 1'b1;
					end else if (half_tick) begin
						// Select stays high a half period so the device sees the rise
						state_reg <= OTP_H_IDLE;
					end
				end
				default: begin
					state_reg <= OTP_H_IDLE;
				end
			endcase
		end
	end

	assign link.sck = sck_reg;
	assign link.cs_n = cs_n_reg;
	assign link.mosi = mosi_reg;
	assign cmd_ready = ready_reg;
	assign wr_take = take_reg;
	assign rd_valid = rdv_reg;
	assign rd_data = rdd_reg;
	assign done = done_reg;
endmodule
`default_nettype wire

// *** dv/otp_link_checker.sv ***
/*
 * Checker for the serial link between host controller and security register.
 * Assumes sck is made from clk, so every link signal is sampled on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module otp_link_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe_n,
	input wire logic miso
);
	logic sck_reg;
	logic [11:0] cnt_reg;
	logic [7:0] op_reg;

	// ****************************************
	// Frame tracking
	// ****************************************
	// Previous serial clock level for edge detection
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			sck_reg <= 1'b0;
		else
			sck_reg <= sck;
	end

	// Rising serial edges per frame and the opcode they carry
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 12'h000;
			op_reg <= 8'h00;
		end else if (cs_n) begin
			cnt_reg <= 12'h000;
		end else if (sck && !sck_reg) begin
			cnt_reg <= cnt_reg + 12'h001;
			if (cnt_reg < 12'h008)
				op_reg <= {op_reg[6:0], mosi};
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	release_idle_a: assert property (cs_n |-> miso_oe_n)
		else $error("serial output driven while deselected");
	out_on_fall_a: assert property (!miso_oe_n && !$past(miso_oe_n) && $changed(miso_o) |-> $fell(sck))
		else $error("serial output changed off a falling edge");
	mosi_steady_a: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("host data changed while serial clock high");
	sck_idle_low_a: assert property (cs_n && $past(cs_n) |-> !sck)
		else $error("serial clock not idle low between frames");
	sck_half_a: assert property ($rose(sck) |-> sck [*6] ##1 !sck)
		else $error("serial clock high phase not six cycles");
	byte_bound_a: assert property ($rose(cs_n) |-> cnt_reg[2:0] == 3'h0)
		else $error("frame ended off a byte boundary");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*6])
		else $error("select gap between frames too short");
	prog_quiet_a: assert property (!cs_n && cnt_reg >= 12'h008 && op_reg == otp_pkg::OP_PROG |-> miso_oe_n)
		else $error("serial output driven in a program frame");
	read_hdr_a: assert property (!cs_n && cnt_reg >= 12'h008 && cnt_reg < 12'h030
		&& op_reg == otp_pkg::OP_READ |-> miso_oe_n)
		else $error("read data driven before dummy bytes ended");
	read_data_a: assert property (!cs_n && cnt_reg >= 12'h031 && op_reg == otp_pkg::OP_READ |-> !miso_oe_n)
		else $error("read data not driven after dummy bytes");
	miso_pull_a: assert property (miso_oe_n |-> miso)
		else $error("released serial output not at pull-up level");

	read_data_c: cover property (!cs_n && op_reg == otp_pkg::OP_READ && cnt_reg == 12'h031);
	prog_frame_c: cover property ($rose(cs_n) && op_reg == otp_pkg::OP_PROG);
	stat_frame_c: cover property (!cs_n && op_reg == otp_pkg::OP_STAT && cnt_reg == 12'h010);
endmodule
`default_nettype wire

// *** dv/otp_security_register_access_tb.sv ***
/*
 * Self-checking bench: host controller and security register joined by the link.
 * Assumes the device user area returns to erased on reset.
 */
`timescale 1ns/1ps
`default_nettype none
module otp_security_register_access_tb;
	localparam int PCYC = 800;
	localparam logic [7:0] FACT = 8'hc3;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0;
	otp_pkg::otp_cmd_t cmd_op = otp_pkg::OTP_CMD_STAT;
	logic [23:0] cmd_addr = 24'h000000;
	logic [7:0] cmd_len = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic cmd_ready, wr_take, rd_valid, done, busy_o, wel_o, used_o;
	logic [7:0] rd_data;
	logic [7:0] wq [0:255];
	logic [7:0] exp_usr [0:63];
	logic [7:0] rq [$];
	int widx = 0;
	int error_cnt = 0;
	int n_tests = 0;

	// ****************************************
	// Structure
	// ****************************************
	otp_spi_if link();
	otp_dev #(.PROG_CYCLES(PCYC), .FACTORY_DATA({64{FACT}})) i_otp_dev (.clk(clk), .arst_n(arst_n),
		.link(link), .busy_o(busy_o), .wel_o(wel_o), .used_o(used_o));
	otp_host i_otp_host (.clk(clk), .arst_n(arst_n), .link(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data), .cmd_ready(cmd_ready), .wr_take(wr_take),
		.rd_valid(rd_valid), .rd_data(rd_data), .done(done));
	otp_link_checker i_otp_link_checker (.clk(clk), .arst_n(arst_n), .sck(link.sck), .cs_n(link.cs_n),
		.mosi(link.mosi), .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n), .miso(link.miso));

	// 50 MHz system clock
	always #10 clk = ~clk;

	// Present next program byte after each take, collect returned bytes
	always @(negedge clk) begin
		if (wr_take === 1'b1) begin
			widx = widx + 1;
			wr_data = wq[widx[7:0]];
		end
		if (rd_valid === 1'b1)
			rq.push_back(rd_data);
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic do_reset;
		@(negedge clk);
		arst_n = 1'b0;
		foreach (exp_usr[i])
			exp_usr[i] = 8'hff;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask

	// One whole frame, waiting for the host to finish it
	task automatic cmd(input otp_pkg::otp_cmd_t op, input logic [23:0] addr, input logic [7:0] len);
		int n;
		rq.delete();
		widx = 0;
		wr_data = wq[0];
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check({7'h0, cmd_ready}, 8'h01);
		cmd_op = op;
		cmd_addr = addr;
		cmd_len = len;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		check({7'h0, done}, 8'h01);
		repeat (8) @(negedge clk);
	endtask

	task automatic stat_is(input logic [7:0] exp);
		cmd(otp_pkg::OTP_CMD_STAT, 24'h000000, 8'h01);
		check(rq[0], exp);
	endtask

	task automatic read_chk(input logic [23:0] addr, input int n);
		int loc;
		cmd(otp_pkg::OTP_CMD_READ, addr, n[7:0]);
		check(8'(rq.size()), n[7:0]);
		for (int i = 0; i < n; i++) begin
			loc = (addr[6:0] + i) % 128;
			check(rq[i], (loc < 64) ? exp_usr[loc] : FACT);
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_fresh;
		do_reset();
		stat_is(8'h00);
		check({5'h0, busy_o, wel_o, used_o}, 8'h00);
		read_chk(24'h5a5a80, 130);
		$display("test fresh done");
	endtask

	task automatic s_refuse;
		do_reset();
		wq[0] = 8'h11;
		cmd(otp_pkg::OTP_CMD_PROG, 24'h000000, 8'h01);
		check({5'h0, busy_o, wel_o, used_o}, 8'h00);
		cmd(otp_pkg::OTP_CMD_WREN, 24'h000000, 8'h00);
		stat_is(8'h02);
		cmd(otp_pkg::OTP_CMD_PROG, 24'h000000, 8'h00);
		stat_is(8'h00);
		check({7'h0, used_o}, 8'h00);
		read_chk(24'h00003c, 8);
		$display("test refuse done");
	endtask

	task automatic s_prog(input logic [23:0] addr, input int n);
		int k;
		do_reset();
		for (k = 0; k < n; k++) begin
			wq[k] = 8'h40 + k[7:0];
			if (k >= n - 64)
				exp_usr[(addr[5:0] + k) % 64] = wq[k];
		end
		cmd(otp_pkg::OTP_CMD_WREN, 24'h000000, 8'h00);
		cmd(otp_pkg::OTP_CMD_PROG, addr, n[7:0]);
		check({6'h0, busy_o, wel_o}, 8'h02);
		stat_is(8'h01);
		k = 0;
		while (busy_o !== 1'b0 && k < PCYC) begin
			@(negedge clk);
			k++;
		end
		check({7'h0, busy_o}, 8'h00);
		check({7'h0, used_o}, 8'h01);
		read_chk(24'h000000, 64);
		cmd(otp_pkg::OTP_CMD_WREN, 24'h000000, 8'h00);
		wq[0] = 8'h00;
		cmd(otp_pkg::OTP_CMD_PROG, 24'h000040, 8'h01);
		check({6'h0, busy_o, wel_o}, 8'h00);
		read_chk(24'h000020, 64);
		$display("test program done");
	endtask

	// ****************************************
	// Sequence and watchdog
	// ****************************************
	// Main sequence
	initial begin
		s_fresh();
		s_refuse();
		s_prog(24'hfffffe, 3);
		s_prog(24'h00007e, 66);
		wrap_up();
	end

	// Cut a hang short
	initial begin
		#1600000;
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
